// file: hw/flcm_cell.sv
`timescale 1ns/1ps

module flcm_cell
    import flcm_pkg::*;
#(
    parameter int ADDR_W = FLCM_ADDR_W
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              cell_input_a,
    input  wire logic              cell_input_b,
    input  wire logic              cell_input_c,
    input  wire logic              cell_input_d,
    input  wire logic              carry_in,
    input  wire logic              cascade_in,
    input  wire logic              cell_clk_en,
    input  wire logic              clu_sync_clear,
    input  wire logic              clu_sync_load,
    output logic                   comb_out,
    output logic                   reg_out,
    output logic                   carry_out,
    output logic                   cascade_out
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 4) begin : g_bad_addr
        $error("flcm_cell needs at least four address bits");
    end

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_sync_n;

    // Release is synchronised so no flop leaves reset on a split edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_sync_n = rst_sync_reg;

    // ------------------------------------------------------------
    // Address decode shared by both bus paths
    // ------------------------------------------------------------
    function automatic flcm_sel_e dec_addr(input logic [ADDR_W-1:0] addr);
        logic [7:0] a8;
        a8 = 8'(addr);
        if (addr != ADDR_W'(a8))
            dec_addr = FLCM_SEL_NONE;
        else if (a8 == FLCM_CTRL_OFS)
            dec_addr = FLCM_SEL_CTRL;
        else if (a8 == FLCM_LUT_OFS)
            dec_addr = FLCM_SEL_LUT;
        else if (a8 == FLCM_STAT_OFS)
            dec_addr = FLCM_SEL_STAT;
        else
            dec_addr = FLCM_SEL_NONE;
    endfunction

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge_strb(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
        merge_strb = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i])
                merge_strb[i*8 +: 8] = new_w[i*8 +: 8];
        end
    endfunction

    // ------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------
    logic              aw_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic              w_held_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              wr_fire;
    flcm_sel_e         wr_sel;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_sel        = dec_addr(aw_addr_reg);

    // Address and data are taken in either order, then held
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_held_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [31:0]              ctrl_reg;
    logic [FLCM_LUT_BITS-1:0] lut_cfg_reg;
    logic                     cfg_locked;
    logic [31:0]              ctrl_next;
    logic [31:0]              lut_next;

    assign cfg_locked = ctrl_reg[FLCM_LOCK_BIT];
    assign ctrl_next  = merge_strb(ctrl_reg, w_data_reg, w_strb_reg) & FLCM_CTRL_MASK;
    assign lut_next   = merge_strb({16'h0000, lut_cfg_reg}, w_data_reg, w_strb_reg);

    // Once locked, the configuration is frozen until reset
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_reg    <= FLCM_CTRL_RST;
            lut_cfg_reg <= FLCM_LUT_RST;
        end else if (wr_fire && !cfg_locked) begin
            if (wr_sel == FLCM_SEL_CTRL)
                ctrl_reg <= ctrl_next;
            if (wr_sel == FLCM_SEL_LUT)
                lut_cfg_reg <= lut_next[FLCM_LUT_BITS-1:0];
        end
    end

    // Write response: refused writes still answer, with an error
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= FLCM_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            case (wr_sel)
                FLCM_SEL_CTRL,
                FLCM_SEL_LUT: begin
                    bresp_reg <= cfg_locked ? FLCM_RESP_SLVERR : FLCM_RESP_OKAY;
                end
                FLCM_SEL_STAT: begin
                    bresp_reg <= FLCM_RESP_SLVERR;
                end
                default: begin
                    bresp_reg <= FLCM_RESP_DECERR;
                end
            endcase
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Cell datapath
    // ------------------------------------------------------------
    flcm_mode_e mode;
    logic       carry_sel;
    logic       casc_en;
    logic       casc_or;
    logic       pack_en;
    logic [3:0] lut_idx;
    logic       lut_f;
    logic       lut_carry;
    logic       cnt_en;
    logic       cnt_up;
    logic       cnt_step;
    logic       func_val;
    logic       casc_val;
    logic       reg_d;
    logic       cell_q_reg;

    assign mode      = flcm_mode_e'(ctrl_reg[FLCM_MODE_MSB:FLCM_MODE_LSB]);
    assign carry_sel = ctrl_reg[FLCM_CSEL_BIT];
    assign casc_en   = ctrl_reg[FLCM_CASC_BIT];
    assign casc_or   = ctrl_reg[FLCM_COR_BIT];
    assign pack_en   = ctrl_reg[FLCM_PACK_BIT];

    // Count enable and direction ride on the data lines
    assign cnt_en   = cell_input_b;
    assign cnt_up   = cell_input_c;
    assign cnt_step = cnt_en && carry_in;

    // Table index: arithmetic uses carry-in, b, a; normal picks c or carry
    always_comb begin
        if (mode == FLCM_ARITH)
            lut_idx = {1'b0, carry_in, cell_input_b, cell_input_a};
        else
            lut_idx = {cell_input_d, carry_sel ? carry_in : cell_input_c,
                       cell_input_b, cell_input_a};
    end

    flcm_lut #(
        .N (4)
    ) u_lut (
        .mask   (lut_cfg_reg),
        .sel    (lut_idx),
        .split  (mode == FLCM_ARITH),
        .f_main (lut_f),
        .f_aux  (lut_carry)
    );

    // Function value, cascade merge and carry out per mode
    always_comb begin
        case (mode)
            FLCM_ARITH: begin
                func_val  = lut_f;
                carry_out = lut_carry;
            end
            FLCM_COUNTER: begin
                func_val  = cell_q_reg ^ cnt_step;
                carry_out = cnt_step && (cnt_up ? cell_q_reg : !cell_q_reg);
            end
            default: begin
                func_val  = lut_f;
                carry_out = 1'b0;
            end
        endcase
        // Cascade merge stays available in every mode
        if (!casc_en)
            casc_val = func_val;
        else if (casc_or)
            casc_val = func_val | cascade_in;
        else
            casc_val = func_val & cascade_in;
    end

    assign comb_out    = casc_val;
    assign cascade_out = casc_val;
    assign reg_out     = cell_q_reg;

    // Register input: packed register takes d, counter takes next count
    always_comb begin
        if (mode != FLCM_ARITH && mode != FLCM_COUNTER && pack_en)
            reg_d = cell_input_d;
        else if (mode == FLCM_COUNTER)
            reg_d = cell_q_reg ^ cnt_step;
        else
            reg_d = casc_val;
    end

    // Cell register: clear beats load beats data, all under clock enable
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cell_q_reg <= 1'b0;
        end else if (cell_clk_en) begin
            if (clu_sync_clear)
                cell_q_reg <= 1'b0;
            else if (clu_sync_load)
                cell_q_reg <= cell_input_a;
            else
                cell_q_reg <= reg_d;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    flcm_sel_e   rd_sel;
    logic [31:0] stat_word;

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign rd_sel        = dec_addr(s_axi_araddr);

    // Live cell state for software
    always_comb begin
        stat_word                = 32'h0000_0000;
        stat_word[FLCM_ST_COMB]  = comb_out;
        stat_word[FLCM_ST_REG]   = cell_q_reg;
        stat_word[FLCM_ST_CARRY] = carry_out;
        stat_word[FLCM_ST_CASC]  = cascade_out;
        stat_word[FLCM_ST_LOCK]  = cfg_locked;
    end

    // One read at a time; data is captured at the address handshake
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= FLCM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= FLCM_RESP_OKAY;
            case (rd_sel)
                FLCM_SEL_CTRL: rdata_reg <= ctrl_reg;
                FLCM_SEL_LUT:  rdata_reg <= {16'h0000, lut_cfg_reg};
                FLCM_SEL_STAT: rdata_reg <= stat_word;
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= FLCM_RESP_DECERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_sync_n);

    logic hold_step;
    assign hold_step = cell_clk_en && !clu_sync_clear && !clu_sync_load;

    sequence seq_locked_write;
        wr_fire && cfg_locked;
    endsequence

    sequence seq_clear_edge;
        cell_clk_en && clu_sync_clear;
    endsequence

    AST_NORMAL_LUT: assert property (
        (mode == FLCM_NORMAL && !casc_en && !carry_sel)
        |-> comb_out == lut_cfg_reg[{cell_input_d, cell_input_c, cell_input_b, cell_input_a}])
        else $error("normal table output mismatch");

    AST_CARRY_SELECT: assert property (
        (mode == FLCM_NORMAL && !casc_en && carry_sel)
        |-> comb_out == lut_cfg_reg[{cell_input_d, carry_in, cell_input_b, cell_input_a}])
        else $error("carry-in not used as third table input");

    AST_CASCADE_AND: assert property (
        (casc_en && !casc_or && !cascade_in) |-> (!cascade_out && !comb_out))
        else $error("cascade AND did not block");

    AST_CASCADE_OR: assert property (
        (mode == FLCM_ARITH && casc_en && casc_or && cascade_in) |-> cascade_out)
        else $error("cascade OR lost in arithmetic mode");

    AST_PACKED_REG: assert property (
        (mode == FLCM_NORMAL && pack_en && hold_step)
        |=> reg_out == $past(cell_input_d))
        else $error("packed register did not take d");

    AST_ARITH_SUM: assert property (
        (mode == FLCM_ARITH && !casc_en)
        |-> comb_out == lut_cfg_reg[{1'b0, carry_in, cell_input_b, cell_input_a}])
        else $error("arithmetic result mismatch");

    AST_ARITH_CARRY: assert property (
        (mode == FLCM_ARITH)
        |-> carry_out == lut_cfg_reg[{1'b1, carry_in, cell_input_b, cell_input_a}])
        else $error("carry half mismatch");

    AST_ARITH_BOTH: assert property (
        (mode == FLCM_ARITH && hold_step) |=> reg_out == $past(comb_out))
        else $error("registered result differs from combinational");

    AST_CLEAR_WINS: assert property (
        seq_clear_edge |=> !reg_out)
        else $error("clear did not win");

    AST_LOAD: assert property (
        (cell_clk_en && !clu_sync_clear && clu_sync_load) |=> reg_out == $past(cell_input_a))
        else $error("load did not take a");

    AST_NO_CLK_EN: assert property (
        !cell_clk_en |=> $stable(reg_out))
        else $error("register moved without clock enable");

    AST_COUNT_IDLE: assert property (
        (mode == FLCM_COUNTER && hold_step && !cnt_en) |=> $stable(reg_out))
        else $error("counter moved without count enable");

    AST_LOCK_HOLD: assert property (
        seq_locked_write |=> ($stable(ctrl_reg) && $stable(lut_cfg_reg)) ##0 bvalid_reg
        && bresp_reg != FLCM_RESP_OKAY)
        else $error("locked configuration changed");

endmodule

// file: hw/flcm_lut.sv
`timescale 1ns/1ps

// Lookup table that works whole (four inputs) or split in two halves
module flcm_lut
    import flcm_pkg::*;
#(
    parameter int N = 4
) (
    input  wire logic [(1<<N)-1:0] mask,
    input  wire logic [N-1:0]      sel,
    input  wire logic              split,
    output logic                   f_main,
    output logic                   f_aux
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (N != 4) begin : g_bad_n
        $error("flcm_lut supports only four inputs");
    end

    localparam int HALF = 1 << (N - 1);

    logic [HALF-1:0] lo_half;
    logic [HALF-1:0] hi_half;

    // Split mode: low half gives the result, high half the carry
    assign lo_half = mask[HALF-1:0];
    assign hi_half = mask[(1<<N)-1:HALF];
    assign f_main  = split ? lo_half[sel[N-2:0]] : mask[sel];
    assign f_aux   = split ? hi_half[sel[N-2:0]] : 1'b0;

endmodule

// file: hw/flcm_pkg.sv
package flcm_pkg;

    // ------------------------------------------------------------
    // Operating modes of the cell
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FLCM_NORMAL  = 2'b00,
        FLCM_ARITH   = 2'b01,
        FLCM_COUNTER = 2'b10,
        FLCM_SPARE   = 2'b11
    } flcm_mode_e;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int         FLCM_ADDR_W    = 8;
    localparam logic [7:0] FLCM_CTRL_OFS  = 8'h00;
    localparam logic [7:0] FLCM_LUT_OFS   = 8'h04;
    localparam logic [7:0] FLCM_STAT_OFS  = 8'h08;

    // Control register fields
    localparam int FLCM_MODE_LSB  = 0;
    localparam int FLCM_MODE_MSB  = 1;
    localparam int FLCM_CSEL_BIT  = 2;
    localparam int FLCM_CASC_BIT  = 3;
    localparam int FLCM_COR_BIT   = 4;
    localparam int FLCM_PACK_BIT  = 5;
    localparam int FLCM_LOCK_BIT  = 31;
    localparam logic [31:0] FLCM_CTRL_MASK = 32'h8000_003F;
    localparam logic [31:0] FLCM_CTRL_RST  = 32'h0000_0000;

    // Truth table: one 16-entry table, or two 8-entry halves
    localparam int          FLCM_LUT_BITS = 16;
    localparam logic [15:0] FLCM_LUT_RST  = 16'h0000;

    // Status register fields
    localparam int FLCM_ST_COMB  = 0;
    localparam int FLCM_ST_REG   = 1;
    localparam int FLCM_ST_CARRY = 2;
    localparam int FLCM_ST_CASC  = 3;
    localparam int FLCM_ST_LOCK  = 4;

    // AXI responses
    localparam logic [1:0] FLCM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] FLCM_RESP_SLVERR = 2'h2;
    localparam logic [1:0] FLCM_RESP_DECERR = 2'h3;

    // Register selector returned by the address decoder
    typedef enum logic [1:0] {
        FLCM_SEL_CTRL = 2'b00,
        FLCM_SEL_LUT  = 2'b01,
        FLCM_SEL_STAT = 2'b10,
        FLCM_SEL_NONE = 2'b11
    } flcm_sel_e;

endpackage

// file: test/flcm_nbr.sv
`timescale 1ns/1ps

// Upstream neighbour cell that feeds the carry and cascade chains
module flcm_nbr (
    input  wire logic nbr_a,
    input  wire logic nbr_b,
    input  wire logic nbr_c,
    output logic      carry_in,
    output logic      cascade_in
);
    // Neighbour stays purely combinational, so it never fights the shared clear/load
    assign carry_in   = nbr_a & nbr_b;
    assign cascade_in = nbr_c;
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ps

module tb_top;
    import flcm_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        mclk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, ia, ib, ic, id, na, nb, nc;
    logic        cin, casc, en, clr, ld, comb, q, cout, csco;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          bad_count, total_checks;
    // Row: ctrl, table, {d,c,b,a}, {na,nb,nc}, expected {comb,carry,reg}
    logic [31:0] rows [10] = '{{6'h00, 16'hA5C3, 4'h6, 3'b000, 3'h5},
        {6'h04, 16'hA5C3, 4'h2, 3'b110, 3'h5}, {6'h00, 16'hA5C3, 4'h2, 3'b110, 3'h0},
        {6'h08, 16'hFFFF, 4'h0, 3'b000, 3'h0}, {6'h18, 16'h0000, 4'h0, 3'b001, 3'h5},
        {6'h20, 16'h0000, 4'h8, 3'b000, 3'h1}, {6'h01, 16'hE896, 4'hB, 3'b110, 3'h7},
        {6'h09, 16'hE896, 4'h3, 3'b110, 3'h2}, {6'h03, 16'hA5C3, 4'h0, 3'b000, 3'h5},
        {6'h19, 16'h0000, 4'h0, 3'b001, 3'h5}};

    flcm_nbr i_flcm_nbr (.nbr_a(na), .nbr_b(nb), .nbr_c(nc), .carry_in(cin), .cascade_in(casc));
    flcm_cell i_flcm_cell (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cell_input_a(ia), .cell_input_b(ib), .cell_input_c(ic),
        .cell_input_d(id), .carry_in(cin), .cascade_in(casc), .cell_clk_en(en),
        .clu_sync_clear(clr), .clu_sync_load(ld), .comb_out(comb), .reg_out(q),
        .carry_out(cout), .cascade_out(csco));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt,
                          input logic [3:0] st, input logic [1:0] er);
        @(posedge mclk);
        {awaddr, wdata, wstrb} <= {ad, dt, st};
        {awvalid, wvalid, bready} <= 3'b111;
        repeat (40) begin
            @(posedge mclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                bready <= 1'b0;
                chk({30'h0, bresp}, {30'h0, er});
                return;
            end
        end
        bad_count++;
        conclude();
    endtask

    task automatic axi_rd(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
        @(posedge mclk);
        {araddr, arvalid, rready} <= {ad, 2'b11};
        repeat (40) begin
            @(posedge mclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rready <= 1'b0;
                chk(rdata, ed);
                chk({30'h0, rresp}, {30'h0, er});
                return;
            end
        end
        bad_count++;
        conclude();
    endtask

    // Counter step: {en,clr,ld,a,b,c} for one edge, then the register value
    task automatic cstep(input logic [5:0] v, input logic e);
        @(posedge mclk);
        {en, clr, ld, ia, ib, ic} <= v;
        @(posedge mclk);
        en <= 1'b0;
        #1;
        chk(q, e);
    endtask

    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Hang guard well above the longest legal run
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        conclude();
    end

    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, ia, ib, ic, id} = '0;
        {na, nb, nc, en, clr, ld, awaddr, araddr, wdata, wstrb} = '0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        axi_rd(FLCM_CTRL_OFS, 32'h0, FLCM_RESP_OKAY);
        axi_rd(FLCM_LUT_OFS, 32'h0, FLCM_RESP_OKAY);
        axi_rd(FLCM_STAT_OFS, 32'h0, FLCM_RESP_OKAY);
        axi_rd(8'h0C, 32'h0, FLCM_RESP_DECERR);
        axi_wr(8'h10, 32'h1, 4'hF, FLCM_RESP_DECERR);
        axi_wr(FLCM_STAT_OFS, 32'h1F, 4'hF, FLCM_RESP_SLVERR);
        axi_wr(FLCM_LUT_OFS, 32'hFFFF_FFFF, 4'h1, FLCM_RESP_OKAY);
        axi_rd(FLCM_LUT_OFS, 32'h0000_00FF, FLCM_RESP_OKAY);
        // Table-driven combinational and register cases
        foreach (rows[i]) begin
            axi_wr(FLCM_CTRL_OFS, {26'h0, rows[i][31:26]}, 4'hF, FLCM_RESP_OKAY);
            axi_wr(FLCM_LUT_OFS, {16'h0, rows[i][25:10]}, 4'hF, FLCM_RESP_OKAY);
            @(posedge mclk);
            {id, ic, ib, ia, na, nb, nc, en} <= {rows[i][9:3], 1'b1};
            @(posedge mclk);
            en <= 1'b0;
            #1;
            chk(comb, rows[i][2]);
            chk(csco, rows[i][2]);
            chk(q, rows[i][0]);
            if (rows[i][27:26] == 2'h1) chk(cout, rows[i][1]);
        end
        // Counter mode with carry-in held high
        axi_wr(FLCM_CTRL_OFS, 32'h2, 4'hF, FLCM_RESP_OKAY);
        {na, nb, nc} <= 3'b110;
        cstep(6'b110000, 1'b0);
        cstep(6'b100011, 1'b1);
        chk(cout, 1'b1);
        chk(comb, 1'b0);
        axi_rd(FLCM_STAT_OFS, 32'h6, FLCM_RESP_OKAY);
        cstep(6'b100010, 1'b0);
        cstep(6'b100000, 1'b0);
        cstep(6'b001100, 1'b0);
        cstep(6'b101010, 1'b0);
        cstep(6'b101100, 1'b1);
        cstep(6'b111100, 1'b0);
        en <= 1'b0;
        // Locked configuration refuses changes until reset
        axi_wr(FLCM_CTRL_OFS, 32'h8000_0001, 4'hF, FLCM_RESP_OKAY);
        axi_wr(FLCM_CTRL_OFS, 32'h0, 4'hF, FLCM_RESP_SLVERR);
        axi_wr(FLCM_LUT_OFS, 32'h0, 4'hF, FLCM_RESP_SLVERR);
        axi_rd(FLCM_CTRL_OFS, 32'h8000_0001, FLCM_RESP_OKAY);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        axi_rd(FLCM_CTRL_OFS, 32'h0, FLCM_RESP_OKAY);
        axi_rd(FLCM_LUT_OFS, 32'h0, FLCM_RESP_OKAY);
        conclude();
    end
endmodule
